// ===== eplk_params.svh
// Constants for the code EPROM program, verify and lock block
`ifndef EPLK_PARAMS_SVH
`define EPLK_PARAMS_SVH
// Mode-select codes {p2_6, p2_7, p3_3, p3_6, p3_7}
`define EPLK_MODE_PROG_CODE 5'h0f
`define EPLK_MODE_VERIFY 5'h03
`define EPLK_MODE_PROG_ENC 5'h0d
`define EPLK_MODE_LOCK1 5'h1f
`define EPLK_MODE_LOCK2 5'h1c
`define EPLK_MODE_LOCK3 5'h16
`define EPLK_MODE_SIG 5'h00
// Signature locations
`define EPLK_SIG_ADDR0 14'h0030
`define EPLK_SIG_ADDR1 14'h0031
`define EPLK_SIG_ADDR2 14'h0060
`define EPLK_ERASED_BYTE 8'hff
`define EPLK_VERIFY_LOCK_PAT 8'hff
`define EPLK_ENC_IDX_W 6
// Register byte offsets
`define EPLK_REG_CTRL 4'h0
`define EPLK_REG_STATUS 4'h4
`define EPLK_REG_PULSES 4'h8
`define EPLK_REG_REFUSED 4'hc
`define EPLK_CTRL_ERASE_BIT 0
// Response time limit: 48 oscillator periods at the fastest 6 MHz, in sys_clk cycles
`define EPLK_OSC_PERIODS 48
`define EPLK_OSC_MAX_KHZ 6000
`define EPLK_SYS_CLK_MHZ 250
`endif

// ===== eplk_pkg.sv
// Types for the code EPROM program, verify and lock block
package eplk_pkg;
  typedef enum logic [2:0] {
    EPLK_MODE_IDLE = 3'h0,
    EPLK_MODE_PCODE = 3'h1,
    EPLK_MODE_PENC = 3'h2,
    EPLK_MODE_PLOCK = 3'h3,
    EPLK_MODE_VRFY = 3'h4,
    EPLK_MODE_SIGR = 3'h5
  } eplk_mode_e;
  typedef logic [7:0] eplk_byte_t;
endpackage

// ===== eplk_top.sv
// Code EPROM program, verify, signature and lock logic with a Wishbone slave
//
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
`include "eplk_params.svh"
module eplk_top #(
  parameter int ADDR_W = 14,
  parameter logic [7:0] SIG_BYTE0 = 8'h5a, // Arbitrary identification value
  parameter logic [7:0] SIG_BYTE1 = 8'h3c, // Arbitrary identification value
  parameter logic [7:0] SIG_BYTE2 = 8'h96  // Arbitrary identification value
) (
  input wire logic sys_clk,
  input wire logic srst,
  // Programmer pins
  input wire logic prog_reset_level,
  input wire logic program_store_strobe_n,
  input wire logic write_strobe_n,
  input wire logic high_voltage_input,
  input wire logic [4:0] mode_sel,
  input wire logic [ADDR_W-1:0] prog_addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  // Core side
  input wire logic external_fetch_select,
  output logic external_fetch_eff,
  output logic table_read_block,
  output logic ext_exec_block,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import eplk_pkg::*;

  localparam int DEPTH = 1 << ADDR_W;
  localparam int ENC_DEPTH = 1 << `EPLK_ENC_IDX_W;
  localparam int SYNC_W = ADDR_W + 8 + 5 + 5;
  localparam int LAT_LIMIT = (`EPLK_OSC_PERIODS * `EPLK_SYS_CLK_MHZ * 1000)
                             / `EPLK_OSC_MAX_KHZ;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
  logic [ADDR_W-1:0] addr_s;
  logic [7:0] din_s;
  logic [4:0] mode_s;
  logic rst_lvl_s, pss_n_s, ws_n_s, hv_s, ext_sel_s;

  always_comb begin
    nxt_sync1 = {prog_addr, data_in, mode_sel, prog_reset_level, program_store_strobe_n,
                 write_strobe_n, high_voltage_input, external_fetch_select};
    nxt_sync2 = sync1_ff;
    {addr_s, din_s, mode_s, rst_lvl_s, pss_n_s, ws_n_s, hv_s, ext_sel_s} = sync2_ff;
  end

  always_ff @(posedge sys_clk) begin
    sync1_ff <= nxt_sync1;
    sync2_ff <= nxt_sync2;
  end

  // ----------------------------------------------------------------
  // Mode decode and strobe edge
  // ----------------------------------------------------------------
  eplk_mode_e mode;
  logic ws_prev_ff, nxt_ws_prev, strobe_fall;

  always_comb begin
    mode = EPLK_MODE_IDLE;
    if (rst_lvl_s && !pss_n_s) begin
      unique case (mode_s)
        `EPLK_MODE_PROG_CODE: mode = EPLK_MODE_PCODE;
        `EPLK_MODE_PROG_ENC: mode = EPLK_MODE_PENC;
        `EPLK_MODE_LOCK1, `EPLK_MODE_LOCK2, `EPLK_MODE_LOCK3: mode = EPLK_MODE_PLOCK;
        `EPLK_MODE_VERIFY: mode = EPLK_MODE_VRFY;
        `EPLK_MODE_SIG: mode = EPLK_MODE_SIGR;
        default: mode = EPLK_MODE_IDLE;
      endcase
    end
    nxt_ws_prev = ws_n_s;
    strobe_fall = ws_prev_ff && !ws_n_s;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ws_prev_ff <= 1'b1;
    end else begin
      ws_prev_ff <= nxt_ws_prev;
    end
  end

  // ----------------------------------------------------------------
  // Nonvolatile arrays: code, encryption, lock bits (1 = programmed)
  // ----------------------------------------------------------------
  eplk_byte_t code_mem [DEPTH];
  eplk_byte_t enc_mem [ENC_DEPTH];
  logic [2:0] lock_ff, nxt_lock;
  logic prog_lock, verify_lock, exec_lock, write_ok, erase_req;
  logic code_we, enc_we;
  logic [`EPLK_ENC_IDX_W-1:0] enc_idx;

  always_comb begin
    prog_lock = lock_ff[0];
    verify_lock = lock_ff[0] && lock_ff[1];
    exec_lock = &lock_ff;
    enc_idx = addr_s[`EPLK_ENC_IDX_W-1:0];
    write_ok = strobe_fall && hv_s && !prog_lock;
    code_we = write_ok && (mode == EPLK_MODE_PCODE);
    enc_we = write_ok && (mode == EPLK_MODE_PENC);
    nxt_lock = lock_ff;
    if (erase_req) begin
      nxt_lock = 3'h0;
    end else if (write_ok && (mode == EPLK_MODE_PLOCK)) begin
      unique case (mode_s)
        `EPLK_MODE_LOCK1: nxt_lock[0] = 1'b1;
        `EPLK_MODE_LOCK2: nxt_lock[1] = 1'b1;
        default: nxt_lock[2] = 1'b1;
      endcase
    end
  end

  // Arrays keep contents across srst; only erase returns them to ones, and the lock bits to zeros
  always_ff @(posedge sys_clk) begin
    lock_ff <= nxt_lock;
  end

  // EPROM cells only go from one to zero when programmed
  always_ff @(posedge sys_clk) begin
    if (erase_req) begin
      for (int i = 0; i < DEPTH; i++) begin
        code_mem[i] <= `EPLK_ERASED_BYTE;
      end
    end else if (code_we) begin
      code_mem[addr_s] <= code_mem[addr_s] & din_s;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (erase_req) begin
      for (int i = 0; i < ENC_DEPTH; i++) begin
        enc_mem[i] <= `EPLK_ERASED_BYTE;
      end
    end else if (enc_we) begin
      enc_mem[enc_idx] <= enc_mem[enc_idx] & din_s;
    end
  end

  // ----------------------------------------------------------------
  // Verify and signature read path
  // ----------------------------------------------------------------
  logic [7:0] data_out_ff, nxt_data_out;
  logic data_oe_ff, nxt_data_oe;
  eplk_byte_t code_rd, enc_rd;

  always_comb begin
    code_rd = code_mem[addr_s];
    enc_rd = enc_mem[enc_idx];
    nxt_data_out = data_out_ff;
    nxt_data_oe = 1'b0;
    if (mode == EPLK_MODE_VRFY) begin
      nxt_data_oe = 1'b1;
      if (verify_lock) begin
        nxt_data_out = `EPLK_VERIFY_LOCK_PAT;
      end else begin
        nxt_data_out = ~(code_rd ^ enc_rd);
      end
    end else if (mode == EPLK_MODE_SIGR) begin
      nxt_data_oe = 1'b1;
      unique case (addr_s)
        `EPLK_SIG_ADDR0: nxt_data_out = SIG_BYTE0;
        `EPLK_SIG_ADDR1: nxt_data_out = SIG_BYTE1;
        `EPLK_SIG_ADDR2: nxt_data_out = SIG_BYTE2;
        default: nxt_data_out = `EPLK_ERASED_BYTE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      data_out_ff <= 8'h00;
      data_oe_ff <= 1'b0;
    end else begin
      data_out_ff <= nxt_data_out;
      data_oe_ff <= nxt_data_oe;
    end
  end

  // ----------------------------------------------------------------
  // Core-side protections and fetch-select latch
  // ----------------------------------------------------------------
  logic srst_d_ff, ext_latched_ff, nxt_ext_latched;
  logic ext_eff_ff, tbl_blk_ff, exec_blk_ff, nxt_ext_eff;

  // Captured in the first cycle after reset release, never under reset
  always_comb begin
    nxt_ext_latched = (srst_d_ff && !srst) ? ext_sel_s : ext_latched_ff;
    nxt_ext_eff = prog_lock ? ext_latched_ff : ext_sel_s;
  end

  always_ff @(posedge sys_clk) begin
    srst_d_ff <= srst;
    if (srst) begin
      ext_latched_ff <= 1'b0;
      ext_eff_ff <= 1'b0;
      tbl_blk_ff <= 1'b0;
      exec_blk_ff <= 1'b0;
    end else begin
      ext_latched_ff <= nxt_ext_latched;
      ext_eff_ff <= nxt_ext_eff;
      tbl_blk_ff <= prog_lock;
      exec_blk_ff <= exec_lock;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone register slave
  // ----------------------------------------------------------------
  logic ack_ff, nxt_ack, bus_req;
  logic [31:0] dat_ff, nxt_dat;
  logic [15:0] pulses_ff, nxt_pulses, refused_ff, nxt_refused;
  logic [2:0] level;

  always_comb begin
    bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
    nxt_ack = bus_req;
    erase_req = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == `EPLK_REG_CTRL)
                && wb_dat_i[`EPLK_CTRL_ERASE_BIT];
    unique case (lock_ff)
      3'h0: level = 3'h1;
      3'h1: level = 3'h2;
      3'h3: level = 3'h3;
      3'h7: level = 3'h4;
      default: level = 3'h0;
    endcase
    // Only pulses that really write a cell count as accepted
    nxt_pulses = pulses_ff + 16'(code_we || enc_we || (write_ok && mode == EPLK_MODE_PLOCK));
    nxt_refused = refused_ff + 16'(strobe_fall && !write_ok);
    nxt_dat = 32'h0;
    if (bus_req && !wb_we_i) begin
      unique case (wb_adr_i)
        `EPLK_REG_STATUS: nxt_dat = {24'h0, rst_lvl_s, ext_latched_ff, level, lock_ff};
        `EPLK_REG_PULSES: nxt_dat = {16'h0, pulses_ff};
        `EPLK_REG_REFUSED: nxt_dat = {16'h0, refused_ff};
        default: nxt_dat = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0;
      pulses_ff <= 16'h0;
      refused_ff <= 16'h0;
    end else begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
      pulses_ff <= nxt_pulses;
      refused_ff <= nxt_refused;
    end
  end

  assign data_out = data_out_ff;
  assign data_oe = data_oe_ff;
  assign external_fetch_eff = ext_eff_ff;
  assign table_read_block = tbl_blk_ff;
  assign ext_exec_block = exec_blk_ff;
  assign wb_dat_o = dat_ff;
  assign wb_ack_o = ack_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sig_byte_a: assert property (mode == EPLK_MODE_SIGR && addr_s == `EPLK_SIG_ADDR0
    |=> data_oe && data_out == SIG_BYTE0) else $error("signature byte wrong");
  no_lock_a: assert property (lock_ff == 3'h0
    |-> ##1 !table_read_block && !ext_exec_block) else $error("protection with no lock");
  prog_refused_a: assert property (prog_lock && code_we == 1'b0 && strobe_fall
    |=> refused_ff == $past(refused_ff) + 16'h1) else $error("locked pulse not refused");
  tbl_block_a: assert property ($rose(lock_ff[0]) |=> table_read_block)
    else $error("table read not blocked");
  verify_lock_a: assert property (verify_lock && mode == EPLK_MODE_VRFY
    |=> data_out == `EPLK_VERIFY_LOCK_PAT) else $error("verify not refused");
  exec_lock_a: assert property (exec_lock |=> ext_exec_block)
    else $error("external execution not blocked");
  read_latency_a: assert property ($rose(mode == EPLK_MODE_VRFY) |-> ##[1:4] data_oe)
    else $error("verify data late");
  release_a: assert property ($fell(mode == EPLK_MODE_VRFY || mode == EPLK_MODE_SIGR)
    |-> ##1 !data_oe) else $error("data lines not released");
  // Array reads taken one cycle back, so a write in that cycle cannot confuse it
  enc_xnor_a: assert property (!verify_lock && mode == EPLK_MODE_VRFY
    |=> data_out == ~($past(code_rd) ^ $past(enc_rd))) else $error("xnor wrong");
  // Lock bits start unknown, so watch their rising edges rather than equality
  no_hv_write_a: assert property (!hv_s |-> (!code_we && !enc_we)
    ##1 (!$rose(lock_ff[0]) && !$rose(lock_ff[1]) && !$rose(lock_ff[2])))
    else $error("write without voltage");

  verify_seen_c: cover property (mode == EPLK_MODE_VRFY ##1 data_oe);
  code_write_c: cover property (code_we);
  level4_c: cover property (level == 3'h4);
  sig_read_c: cover property (mode == EPLK_MODE_SIGR ##1 data_oe);

endmodule // eplk_top

// ===== eplk_prog_model.sv
// Behavioural EPROM programmer driving the programming pins
`timescale 1ns/100ps
`include "eplk_params.svh"
module eplk_prog_model #(
  parameter int SETUP = 8,
  parameter int LOW = 12,
  parameter int GAP = 6
) (
  input wire logic sys_clk,
  output logic prog_reset_level,
  output logic program_store_strobe_n,
  output logic write_strobe_n,
  output logic high_voltage_input,
  output logic [4:0] mode_sel,
  output logic [13:0] prog_addr,
  output logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe
);
  // --------------------------------------------------------------
  // Pin timing, shortened from oscillator periods and microseconds
  // --------------------------------------------------------------
  initial begin
    prog_reset_level = 1'b1;
    program_store_strobe_n = 1'b0;
    write_strobe_n = 1'b1;
    high_voltage_input = 1'b0;
    mode_sel = 5'h1e;
    prog_addr = 14'h0000;
    data_in = 8'h00;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic write_loc(input logic [4:0] m, input logic [13:0] a, input logic [7:0] d,
                           input int pulses, input logic vpp);
    mode_sel <= m;
    prog_addr <= a;
    data_in <= d;
    cyc(SETUP);
    high_voltage_input <= vpp;
    cyc(SETUP);
    repeat (pulses) begin
      write_strobe_n <= 1'b0;
      cyc(LOW);
      write_strobe_n <= 1'b1;
      cyc(GAP);
    end
    cyc(SETUP);
    high_voltage_input <= 1'b0;
    cyc(SETUP);
    mode_sel <= 5'h1e;
    // Released lines must not keep showing the last byte
    data_in <= ~d;
    cyc(SETUP);
  endtask
  task automatic read_loc(input logic [4:0] m, input logic [13:0] a, output logic [7:0] d,
                          output logic ok);
    logic up;
    logic rel;
    up = 1'b0;
    rel = 1'b0;
    mode_sel <= m;
    prog_addr <= a;
    for (int n = 0; n < 48 && !up; n++) begin
      cyc(1);
      up = (data_oe === 1'b1);
    end
    cyc(2);
    d = data_out;
    mode_sel <= 5'h1e;
    for (int n = 0; n < 48 && !rel; n++) begin
      cyc(1);
      rel = (data_oe === 1'b0);
    end
    ok = up & rel;
  endtask
endmodule // eplk_prog_model

// ===== tb.sv
// Self-checking bench for the EPROM program, verify and lock block
`timescale 1ns/100ps
`include "eplk_params.svh"
module tb;
  import eplk_pkg::*;
  localparam logic [2:0] MASKS [4] = '{3'b001, 3'b011, 3'b111, 3'b100};
  localparam logic [2:0] LEVELS [4] = '{3'h2, 3'h3, 3'h4, 3'h0};
  localparam logic [4:0] LMODE [3] = '{`EPLK_MODE_LOCK1, `EPLK_MODE_LOCK2, `EPLK_MODE_LOCK3};
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic prl, pss_n, write_strobe_n, high_voltage_input, data_oe, wb_ack_o;
  logic external_fetch_eff, table_read_block, ext_exec_block;
  logic [4:0] mode_sel;
  logic [13:0] prog_addr;
  logic [7:0] data_in, data_out, rd;
  logic external_fetch_select = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, q, base;
  logic ok;
  int n_fail = 0;
  int check_count = 0;
  always #2 sys_clk = ~sys_clk;
  eplk_top dut_u (.sys_clk(sys_clk), .srst(srst), .prog_reset_level(prl),
    .program_store_strobe_n(pss_n), .write_strobe_n(write_strobe_n),
    .high_voltage_input(high_voltage_input), .mode_sel(mode_sel), .prog_addr(prog_addr),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .external_fetch_select(external_fetch_select), .external_fetch_eff(external_fetch_eff),
    .table_read_block(table_read_block), .ext_exec_block(ext_exec_block),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  eplk_prog_model prog_u (.sys_clk(sys_clk), .prog_reset_level(prl),
    .program_store_strobe_n(pss_n), .write_strobe_n(write_strobe_n),
    .high_voltage_input(high_voltage_input), .mode_sel(mode_sel), .prog_addr(prog_addr),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
  // ------------------------------------------------
  // Tasks
  // ------------------------------------------------
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge sys_clk);
      if (wb_ack_o === 1'b1) break;
    end
    if (n == 20) begin
      n_fail++;
      $display("Error wishbone ack expected 1 seen 0");
      final_report();
    end
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic pin_read(input logic [4:0] m, input logic [13:0] a, input logic [7:0] exp);
    prog_u.read_loc(m, a, rd, ok);
    chk("pin handshake", 32'h1, {31'h0, ok});
    chk("pin data", {24'h0, exp}, {24'h0, rd});
  endtask
  // ------------------------------------------------
  // Sequence
  // ------------------------------------------------
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_fail++;
    $display("Error run limit expected finish seen timeout");
    final_report();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    // Arrays power up unknown, so erase first
    wb(1'b1, `EPLK_REG_CTRL, 32'h1, q);
    wb(1'b0, 4'h2, 32'h0, q);
    chk("unmapped read", 32'h0, q);
    wb(1'b0, `EPLK_REG_STATUS, 32'h0, q);
    chk("status erased", 32'hc8, q);
    pin_read(`EPLK_MODE_SIG, 14'h0030, 8'h5a);
    pin_read(`EPLK_MODE_SIG, 14'h0031, 8'h3c);
    pin_read(`EPLK_MODE_SIG, 14'h0060, 8'h96);
    pin_read(`EPLK_MODE_SIG, 14'h0032, 8'hff);
    wb(1'b0, `EPLK_REG_PULSES, 32'h0, base);
    prog_u.write_loc(`EPLK_MODE_PROG_CODE, 14'h0005, 8'ha5, 5, 1'b1);
    prog_u.write_loc(`EPLK_MODE_PROG_ENC, 14'h0005, 8'h0f, 25, 1'b1);
    wb(1'b0, `EPLK_REG_PULSES, 32'h0, q);
    chk("pulse count", base + 30, q);
    pin_read(`EPLK_MODE_VERIFY, 14'h0005, ~(8'ha5 ^ 8'h0f));
    pin_read(`EPLK_MODE_VERIFY, 14'h0045, ~(8'hff ^ 8'h0f));
    wb(1'b0, `EPLK_REG_REFUSED, 32'h0, base);
    prog_u.write_loc(`EPLK_MODE_PROG_CODE, 14'h0045, 8'h00, 5, 1'b0);
    wb(1'b0, `EPLK_REG_REFUSED, 32'h0, q);
    chk("refused no voltage", base + 5, q);
    pin_read(`EPLK_MODE_VERIFY, 14'h0045, 8'h0f);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, `EPLK_REG_CTRL, 32'h1, q);
      prog_u.write_loc(`EPLK_MODE_PROG_CODE, 14'h0005, 8'ha5, 5, 1'b1);
      // Third bit first: once the first is set nothing more can be written
      for (int b = 2; b >= 0; b--) begin
        if (MASKS[i][b]) prog_u.write_loc(LMODE[b], 14'h0000, 8'h00, 25, 1'b1);
      end
      wb(1'b0, `EPLK_REG_STATUS, 32'h0, q);
      chk("lock status", 32'hc0 | {26'h0, LEVELS[i], MASKS[i]}, q);
      chk("table read block", {31'h0, MASKS[i][0]}, {31'h0, table_read_block});
      chk("exec block", {31'h0, &MASKS[i]}, {31'h0, ext_exec_block});
      pin_read(`EPLK_MODE_VERIFY, 14'h0005, (MASKS[i][0] & MASKS[i][1]) ? 8'hff : 8'ha5);
      wb(1'b0, `EPLK_REG_REFUSED, 32'h0, base);
      prog_u.write_loc(`EPLK_MODE_PROG_CODE, 14'h0006, 8'h3c, 5, 1'b1);
      wb(1'b0, `EPLK_REG_REFUSED, 32'h0, q);
      chk("locked refusals", base + (MASKS[i][0] ? 5 : 0), q);
      pin_read(`EPLK_MODE_VERIFY, 14'h0006, MASKS[i][0] ? 8'hff : 8'h3c);
      external_fetch_select <= 1'b0;
      repeat (6) @(posedge sys_clk);
      chk("fetch select", {31'h0, MASKS[i][0]}, {31'h0, external_fetch_eff});
      // Mid-run reset latches the low select; lock bits survive it
      srst <= 1'b1;
      repeat (10) @(posedge sys_clk);
      srst <= 1'b0;
      external_fetch_select <= 1'b1;
      repeat (6) @(posedge sys_clk);
      chk("fetch latched", {31'h0, ~MASKS[i][0]}, {31'h0, external_fetch_eff});
      wb(1'b0, `EPLK_REG_STATUS, 32'h0, q);
      chk("lock after reset", 32'h80 | {26'h0, LEVELS[i], MASKS[i]}, q);
      srst <= 1'b1;
      repeat (10) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (6) @(posedge sys_clk);
    end
    final_report();
  end
endmodule // tb
